//--- design/gls_scaler_ctrl.v
// gated latching scaler control with ahb-lite register slave
`include "gls_defs.vh"

module gls_scaler_ctrl #(
  parameter NCH = 32,
  parameter CW = 12,
  parameter EW = 20,
  parameter AW = 20
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output reg [31:0] hrdata,
  output wire hresp,
  input wire [NCH-1:0] cntIn,
  input wire ceN,
  input wire ovfEnable,
  input wire [5:0] memModules,
  input wire [5:0] activeChannels,
  output reg [AW-1:0] memAddr,
  output reg [CW-1:0] memWrData,
  output reg memWr,
  output reg memRd,
  input wire [CW-1:0] memRdData
);

  localparam S_IDLE = 3'd0;
  localparam S_RD1 = 3'd1;
  localparam S_MEM = 3'd2;
  localparam S_MEM2 = 3'd3;
  localparam S_DONE = 3'd4;

  reg [1:0] mode_reg;
  reg full_reg;
  reg [EW-1:0] ceCount_reg;
  reg ceNPrev_reg;
  reg [NCH-1:0] cntInPrev_reg;
  reg [AW:0] wrPtr_reg;
  reg dumping_reg;
  reg [5:0] dumpIdx_reg;
  reg [AW:0] rbAddr_reg;
  reg [`GLS_N_W-1:0] incSel_reg;
  reg [1:0] reply_reg;
  reg [2:0] state_reg;
  reg wPend_reg;
  reg [7:0] dAddr_reg;
  reg dHigh_reg;

  wire accept;
  wire ceRise;
  wire armedLive;
  wire countGate;
  wire snapNow;
  wire clearCnt;
  wire [AW:0] memEnd;
  wire rbValid;
  wire [9:0] nTimesCh;
  wire [8:0] increment;
  wire [NCH*CW-1:0] cntBus;
  wire [NCH*CW-1:0] snapBus;
  wire [CW-1:0] snapWord;
  wire cmdStandby;
  wire cmdArm;
  wire cmdReadback;
  wire wUnmapped;
  reg [31:0] rdValue;

  assign accept = hsel && hready && htrans[1];
  assign hreadyout = (state_reg == S_IDLE) || (state_reg == S_DONE);
  assign hresp = 1'b0;

  // window edge, live only while armed and memory not full
  assign ceRise = ceN && !ceNPrev_reg;
  assign armedLive = (mode_reg == `GLS_MODE_ARMED) && !full_reg;
  assign countGate = armedLive && !ceN;
  assign snapNow = armedLive && ceRise;

  // 32K words per installed module
  assign memEnd = {memModules[AW-`GLS_MODULE_SHIFT:0], {`GLS_MODULE_SHIFT{1'b0}}};

  // data-phase write decode
  assign wUnmapped = dHigh_reg;
  assign cmdStandby = wPend_reg && !wUnmapped && (dAddr_reg == `GLS_OFF_STANDBY);
  assign cmdArm = wPend_reg && !wUnmapped && (dAddr_reg == `GLS_OFF_ARM);
  assign cmdReadback = wPend_reg && !wUnmapped && (dAddr_reg == `GLS_OFF_READBACK);
  assign clearCnt = snapNow || cmdArm;

  // channel counters and snapshot latches
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi = gi + 1) begin : gChan
      reg [CW-1:0] cnt_reg;
      reg [CW-1:0] snap_reg;
      always @(posedge sys_clk) begin
        if (sys_rst) begin
          cnt_reg <= {CW{1'b0}};
          snap_reg <= {CW{1'b0}};
        end else begin
          if (snapNow) begin
            snap_reg <= cnt_reg;
          end
          if (clearCnt) begin
            cnt_reg <= {CW{1'b0}};
          end else if (countGate && cntIn[gi] && !cntInPrev_reg[gi]) begin
            if (cnt_reg != {CW{1'b1}} || ovfEnable) begin
              cnt_reg <= cnt_reg + {{(CW-1){1'b0}}, 1'b1};
            end
          end
        end
      end
      assign cntBus[gi*CW +: CW] = cnt_reg;
      assign snapBus[gi*CW +: CW] = snap_reg;
    end
  endgenerate

  assign snapWord = snapBus[dumpIdx_reg[4:0]*CW +: CW];

  // readback increment from subaddress n
  assign nTimesCh = incSel_reg * activeChannels;
  assign increment = (incSel_reg == `GLS_N_ZERO) ? 9'h001 :
    (incSel_reg <= `GLS_N_MAX) ? nTimesCh[8:0] : {3'b000, activeChannels};
  assign rbValid = (mode_reg == `GLS_MODE_READBACK) && (rbAddr_reg < memEnd);

  // register read mux, answers carry q and x on bits 24 and 25
  always @* begin
    rdValue = 32'h0000_0000;
    if (dHigh_reg) begin
      rdValue = 32'h0000_0000;
    end else if (dAddr_reg == `GLS_OFF_STATUS) begin
      rdValue = {6'h00, 2'b11, 20'h00000, full_reg, ovfEnable, mode_reg};
    end else if (dAddr_reg == `GLS_OFF_CECNT) begin
      rdValue = {6'h00, 2'b11, 4'h0, ceCount_reg};
    end else if (dAddr_reg == `GLS_OFF_MEMMOD) begin
      rdValue = {6'h00, 2'b11, 18'h00000, memModules};
    end else if (dAddr_reg == `GLS_OFF_ACTCH) begin
      rdValue = {6'h00, 2'b11, 18'h00000, activeChannels};
    end else if (dAddr_reg == `GLS_OFF_ID) begin
      rdValue = {6'h00, 2'b11, `GLS_ID_VALUE};
    end else if (dAddr_reg == `GLS_OFF_REPLY) begin
      rdValue = {6'h00, reply_reg, 24'h000000};
    end else if (dAddr_reg == `GLS_OFF_RBDATA) begin
      rdValue = {6'h00, 2'b10, 24'h000000};
    end
  end

  // ahb-lite slave sequencing
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= S_IDLE;
      wPend_reg <= 1'b0;
      dAddr_reg <= 8'h00;
      dHigh_reg <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      case (state_reg)
        S_IDLE, S_DONE: begin
          wPend_reg <= 1'b0;
          state_reg <= S_IDLE;
          if (accept) begin
            dAddr_reg <= haddr[7:0];
            dHigh_reg <= |haddr[31:8];
            if (hwrite) begin
              wPend_reg <= 1'b1;
            end else begin
              state_reg <= S_RD1;
            end
          end
        end
        S_RD1: begin
          if (!dHigh_reg && dAddr_reg == `GLS_OFF_RBDATA && rbValid) begin
            state_reg <= S_MEM;
          end else begin
            hrdata <= rdValue;
            state_reg <= S_DONE;
          end
        end
        S_MEM: begin
          state_reg <= S_MEM2;
        end
        S_MEM2: begin
          hrdata <= {6'h00, 2'b11, 12'h000, memRdData};
          state_reg <= S_DONE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // mode, event counter, memory writer and readback address
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      mode_reg <= `GLS_MODE_STANDBY;
      full_reg <= 1'b0;
      ceCount_reg <= {EW{1'b0}};
      ceNPrev_reg <= 1'b1;
      cntInPrev_reg <= {NCH{1'b0}};
      wrPtr_reg <= {(AW+1){1'b0}};
      dumping_reg <= 1'b0;
      dumpIdx_reg <= 6'h00;
      rbAddr_reg <= {(AW+1){1'b0}};
      incSel_reg <= `GLS_N_ZERO;
      reply_reg <= 2'b00;
      memAddr <= {AW{1'b0}};
      memWrData <= {CW{1'b0}};
      memWr <= 1'b0;
      memRd <= 1'b0;
    end else begin
      ceNPrev_reg <= ceN;
      cntInPrev_reg <= cntIn;
      memWr <= 1'b0;
      memRd <= 1'b0;

      // count-enable events while armed and not full
      if (snapNow) begin
        ceCount_reg <= ceCount_reg + {{(EW-1){1'b0}}, 1'b1};
        dumping_reg <= 1'b1;
        dumpIdx_reg <= 6'h00;
      end

      // interleaved write of the latched sample set
      if (dumping_reg && mode_reg == `GLS_MODE_ARMED) begin
        if (wrPtr_reg >= memEnd) begin
          full_reg <= 1'b1;
          dumping_reg <= 1'b0;
        end else begin
          memWr <= 1'b1;
          memAddr <= wrPtr_reg[AW-1:0];
          memWrData <= snapWord;
          wrPtr_reg <= wrPtr_reg + {{AW{1'b0}}, 1'b1};
          dumpIdx_reg <= dumpIdx_reg + 6'h01;
          if (wrPtr_reg + {{AW{1'b0}}, 1'b1} >= memEnd) begin
            full_reg <= 1'b1;
            dumping_reg <= 1'b0;
          end
          if (dumpIdx_reg + 6'h01 >= activeChannels) begin
            dumping_reg <= 1'b0;
          end
        end
      end else if (dumping_reg) begin
        dumping_reg <= 1'b0;
      end

      // readback word fetch and address advance
      if (state_reg == S_RD1 && !dHigh_reg && dAddr_reg == `GLS_OFF_RBDATA && rbValid) begin
        memRd <= 1'b1;
        memAddr <= rbAddr_reg[AW-1:0];
        rbAddr_reg <= rbAddr_reg + {{(AW-8){1'b0}}, increment};
      end

      // held clear in standby
      if (mode_reg == `GLS_MODE_STANDBY) begin
        ceCount_reg <= {EW{1'b0}};
      end

      // mode commands, accepted at any time
      if (wPend_reg) begin
        reply_reg <= 2'b00;
      end
      if (cmdStandby) begin
        mode_reg <= `GLS_MODE_STANDBY;
        ceCount_reg <= {EW{1'b0}};
        full_reg <= 1'b0;
        dumping_reg <= 1'b0;
        reply_reg <= 2'b11;
      end else if (cmdArm) begin
        mode_reg <= `GLS_MODE_ARMED;
        ceCount_reg <= {EW{1'b0}};
        full_reg <= 1'b0;
        wrPtr_reg <= {(AW+1){1'b0}};
        dumping_reg <= 1'b0;
        reply_reg <= 2'b11;
      end else if (cmdReadback) begin
        mode_reg <= `GLS_MODE_READBACK;
        rbAddr_reg <= {1'b0, hwdata[`GLS_START_W-1:0]};
        incSel_reg <= hwdata[`GLS_N_LSB +: `GLS_N_W];
        dumping_reg <= 1'b0;
        reply_reg <= 2'b11;
      end
    end
  end

endmodule // gls_scaler_ctrl

//--- design/gls_defs.vh
// constants and register map of the gated latching scaler control
//
// Behaviour
// - count-enable is the window for all 32 channels, ignored outside Armed mode
// - each channel counter is 12 bits, plain binary from zero
// - by default a counter saturates at all ones, meaning 4095 or more
// - overflow setting makes counters roll to zero at pulse 4096; shown in status
// - attached memory is 1 to 32 modules of 12-bit words, module count in status; code gives it only at GLS_OFF_MEMMOD, not in status
// - depth per channel is total memory shared among active channels
// - standby at reset, clear or command; counts ignored, readback refused Q=0
// - in Armed mode channels count only while the window is active
// - samples stored channel-interleaved, channel 1 first, then later samples
// - only in Armed mode a 20-bit counter counts window events, readable
// - event counter held clear in Standby and cleared by arm command
// - event counter advances on the low-to-high edge of count-enable
// - at memory end set full, ignore inputs, never wrap, stop event counter
// - memory not a multiple of channels leaves a partial final sample set
// - readback attempted while Armed is refused with Q=0
// - readback starts at given address, then advances by increment 1 to 256
// - reading past memory end returns Q=0; end is 32K words per module
// - readback ignores count inputs and reads at full transfer rate
// - standby command always accepted, clears event counter and full, Q=1 X=1
// - arm command always accepted, clears event counter and full, Q=1 X=1
// - readback command always accepted with Q=1 X=1; n=0 gives increment 1
// - n 1 to 8 gives n times active channels; n 9 to 15 acts as n=1
// - start address on write bits 1 to 20, lsb first, upper lines zero
// - data read returns word then advances; outside readback or past end zeros, Q=0
// - status gives mode 00/01/10 on bits 2:1, overflow on bit 3, full on bit 4
`ifndef GLS_DEFS_VH
`define GLS_DEFS_VH

`define GLS_OFF_STANDBY 8'h00
`define GLS_OFF_ARM 8'h04
`define GLS_OFF_READBACK 8'h08
`define GLS_OFF_RBDATA 8'h0c
`define GLS_OFF_STATUS 8'h10
`define GLS_OFF_CECNT 8'h14
`define GLS_OFF_MEMMOD 8'h18
`define GLS_OFF_ACTCH 8'h1c
`define GLS_OFF_ID 8'h20
`define GLS_OFF_REPLY 8'h24

`define GLS_MODE_STANDBY 2'b00
`define GLS_MODE_ARMED 2'b01
`define GLS_MODE_READBACK 2'b10

`define GLS_Q_BIT 24
`define GLS_X_BIT 25
`define GLS_N_LSB 24
`define GLS_N_W 4
`define GLS_START_W 20
`define GLS_MODULE_SHIFT 15
`define GLS_N_MAX 4'h8
`define GLS_N_ONE 4'h1
`define GLS_N_ZERO 4'h0

// arbitrary identification value
`define GLS_ID_VALUE 24'h00a5c3

`endif

//--- tb/gls_mem_model.sv
// memory module model behind the scaler memory port
module gls_mem_model (
  input wire logic sys_clk,
  input wire logic [19:0] memAddr,
  input wire logic [11:0] memWrData,
  input wire logic memWr,
  input wire logic memRd,
  output logic [11:0] memRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] mem [0:63];
  initial memRdData = 12'h000;
  // read data only valid the cycle after a strobe, otherwise it keeps changing
  always @(posedge sys_clk) begin
    if (memWr) mem[memAddr[5:0]] <= memWrData;
    memRdData <= memRd ? mem[memAddr[5:0]] : ~memRdData;
  end
endmodule // gls_mem_model

//--- tb/gls_scaler_ctrl_checker.sv
// assertion checker for the scaler control ports
module gls_scaler_ctrl_checker #(parameter AW = 20) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic ceN,
  input wire logic [AW-1:0] memAddr,
  input wire logic memWr,
  input wire logic memRd
);
  logic wp;
  logic [7:0] wa;
  logic [1:0] mode;
  logic [3:0] rise;
  wire take = hsel && hready && htrans[1];
  // mode tracked from command writes on the bus
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      wp <= 1'b0;
      wa <= 8'h00;
      mode <= 2'b00;
      rise <= 4'h0;
    end else begin
      rise <= {rise[2:0], $rose(ceN)};
      if (hready) begin
        wp <= take && hwrite && haddr[31:8] == 24'h0;
        wa <= haddr[7:0];
      end
      if (wp && hready && wa == 8'h00) mode <= 2'b00;
      if (wp && hready && wa == 8'h04) mode <= 2'b01;
      if (wp && hready && wa == 8'h08) mode <= 2'b10;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_rst;
    $fell(sys_rst) |-> !memWr && !memRd && memAddr == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("memory port busy after reset");
  property p_wrarm;
    memWr |-> mode == 2'b01 || $past(mode) == 2'b01;
  endproperty
  a_wrarm: assert property (p_wrarm) else $error("memory write outside armed");
  property p_rdrb;
    memRd |-> mode == 2'b10;
  endproperty
  a_rdrb: assert property (p_rdrb) else $error("memory read outside readback");
  property p_stat;
    take && !hwrite && haddr == 32'h10 |=> !hreadyout ##1 hreadyout;
  endproperty
  a_stat: assert property (p_stat) else $error("status read wait wrong");
  property p_wr0;
    take && hwrite |=> hreadyout;
  endproperty
  a_wr0: assert property (p_wr0) else $error("command write stalled");
  property p_seq;
    memWr && $past(memWr) |-> memAddr == $past(memAddr) + 1'b1;
  endproperty
  a_seq: assert property (p_seq) else $error("dump address not consecutive");
  property p_dump;
    $rose(memWr) |-> |rise;
  endproperty
  a_dump: assert property (p_dump) else $error("dump without window close");
  property p_rbwait;
    memRd |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rbwait: assert property (p_rbwait) else $error("readback wait wrong");
endmodule // gls_scaler_ctrl_checker

bind gls_scaler_ctrl gls_scaler_ctrl_checker #(.AW(AW)) chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .ceN(ceN),
  .memAddr(memAddr), .memWr(memWr), .memRd(memRd));

//--- tb/test_gls_scaler_ctrl.sv
// testbench of the scaler control
module test_gls_scaler_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, sys_rst, hsel, hwrite, ceN, ovfEnable, memWr, memRd, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, cntIn, r;
  logic [5:0] memModules, activeChannels;
  logic [19:0] memAddr;
  logic [11:0] memWrData, memRdData;
  wire hready = hreadyout;
  int errorCnt = 0;
  int nTests = 0;
  gls_scaler_ctrl uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .cntIn(cntIn), .ceN(ceN), .ovfEnable(ovfEnable), .memModules(memModules),
    .activeChannels(activeChannels), .memAddr(memAddr), .memWrData(memWrData), .memWr(memWr), .memRd(memRd),
    .memRdData(memRdData));
  gls_mem_model mem (.sys_clk(sys_clk), .memAddr(memAddr), .memWrData(memWrData), .memWr(memWr), .memRd(memRd),
    .memRdData(memRdData));
  always #12.5 sys_clk = ~sys_clk;
  task report_and_stop;
    $display("checks %0d errors %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    nTests++;
    if (s !== e) begin
      errorCnt++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // one single transfer, address phase then data phase
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(negedge sys_clk); while (hreadyout !== 1'b1);
    @(posedge sys_clk);
    htrans <= 2'b00;
    hwdata <= d;
    do @(negedge sys_clk); while (hreadyout !== 1'b1);
    r = hrdata;
    @(posedge sys_clk);
  endtask
  task rd(input logic [31:0] a, input logic [31:0] e, input string n);
    ahb(1'b0, a, 32'h0);
    chk(n, r, e);
  endtask
  // window of 8400 cycles, channel 1..3 get a, b, c pulses
  task win(input int a, input int b, input int c);
    ceN <= 1'b0;
    for (int i = 0; i < 8400; i++) begin
      @(posedge sys_clk);
      cntIn <= {29'h0, i < 2 * c && !i[0], i < 2 * b && !i[0], i < 2 * a && !i[0]};
    end
    ceN <= 1'b1;
    repeat (60) @(posedge sys_clk);
  endtask
  task t_idle;
    rd(32'h10, 32'h0300_0000, "status");
    rd(32'h18, 32'h0300_0001, "modules");
    rd(32'h1c, 32'h0300_0003, "channels");
    rd(32'h20, 32'h0300_a5c3, "ident");
    rd(32'h0c, 32'h0200_0000, "rbdata");
    ahb(1'b1, 32'h100, 32'h0);
    rd(32'h24, 32'h0000_0000, "reply");
    rd(32'h100, 32'h0000_0000, "unmapped");
    win(2, 2, 2);
    rd(32'h14, 32'h0300_0000, "cecnt");
  endtask
  task t_arm;
    ahb(1'b1, 32'h04, 32'h0);
    rd(32'h24, 32'h0300_0000, "reply");
    rd(32'h10, 32'h0300_0001, "status");
    win(3, 5, 4100);
    ovfEnable <= 1'b1;
    win(0, 1, 4097);
    rd(32'h14, 32'h0300_0002, "cecnt");
    rd(32'h0c, 32'h0200_0000, "rbdata");
    rd(32'h10, 32'h0300_0005, "status");
  endtask
  task t_readback;
    logic [11:0] w [0:5];
    w = '{12'h003, 12'h005, 12'hfff, 12'h000, 12'h001, 12'h001};
    ahb(1'b1, 32'h08, 32'h0000_0000);
    for (int i = 0; i < 6; i++) rd(32'h0c, {20'h03000, w[i]}, "word");
    ahb(1'b1, 32'h08, 32'h0100_0001);
    rd(32'h0c, 32'h0300_0005, "inc1");
    rd(32'h0c, 32'h0300_0001, "inc1");
    ahb(1'b1, 32'h08, 32'h0900_0002);
    rd(32'h0c, 32'h0300_0fff, "inc9");
    rd(32'h0c, 32'h0300_0001, "inc9");
    ahb(1'b1, 32'h08, 32'h0000_8000);
    rd(32'h0c, 32'h0200_0000, "end");
    rd(32'h10, 32'h0300_0006, "status");
    win(1, 1, 1);
    rd(32'h14, 32'h0300_0002, "cecnt");
    ahb(1'b1, 32'h08, 32'h0000_0000);
    rd(32'h0c, 32'h0300_0003, "word");
  endtask
  task t_back;
    ahb(1'b1, 32'h04, 32'h0);
    rd(32'h14, 32'h0300_0000, "cecnt");
    ahb(1'b1, 32'h00, 32'h0);
    rd(32'h24, 32'h0300_0000, "reply");
    rd(32'h10, 32'h0300_0004, "status");
  endtask
  initial begin
    sys_clk = 1'b0;
    sys_rst = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata, cntIn, ovfEnable} = '0;
    hsize = 3'h2;
    ceN = 1'b1;
    memModules = 6'h01;
    activeChannels = 6'h03;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    t_idle();
    t_arm();
    t_readback();
    t_back();
    report_and_stop();
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    errorCnt++;
    report_and_stop();
  end
endmodule // test_gls_scaler_ctrl
